// >>> usmc_uart_modem.sv
// file: APB serial port top with modem control, loopback and event interrupt
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - stop bit 0 sends one stop; 1 sends 1.5 for 5-bit, else 2.
// - length code 00..11 picks 5..8 data bits, framing excluded.
// - receiver samples only the first stop bit.
// - loopback holds serial output at mark.
// - loopback disconnects the receive pin.
// - loopback feeds transmit shifter into receive shifter.
// - loopback disconnects the four handshake input pins.
// - loopback maps terminal-ready, request, user1, gate onto set-ready, clear, ring, carrier.
// - loopback forces handshake output pins high.
// - receive and transmit events keep working in loopback.
// - loopback handshake events come from control bits, still masked.
// - gate bit 3 enables the interrupt pin; 0 floats it.
// - user output one bit drives no pin; readable and writable, and in loopback drives ring.
// - bit 0 set drives terminal-ready pin low, clear drives it high.
// - bit 1 drives request-send pin the same inverted way.
module usmc_uart_modem
  import usmc_pkg::*;
#(
  parameter int DIV_W = 16
)
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             serialOut,
  input  wire logic        serialIn,
  output logic             terminal_ready_out_n,
  output logic             request_send_out_n,
  input  wire logic        clear_send_in_n,
  input  wire logic        set_ready_in_n,
  input  wire logic        ring_in_n,
  input  wire logic        carrier_detect_in_n,
  output logic             irqOut,
  output logic             irqOutEn
);
  initial
  begin
    if (DIV_W < 4 || DIV_W > 16)
      $error("DIV_W must be 4..16");
  end

  logic [7:0]       modem_line_control_reg;
  logic [2:0]       lineFormat_reg;
  logic [15:0]      baudDiv_reg;
  logic [EV_W-1:0]  evStatus_reg;
  logic [EV_W-1:0]  evMask_reg;
  logic [7:0]       txHold_reg;
  logic             txPend_reg;
  logic [DIV_W-1:0] divCnt_reg;
  logic             bitTick;

  logic loopback;
  assign loopback = modem_line_control_reg[LOOPBACK_BIT];

  // pin synchronisers: first stage feeds only the second
  logic [4:0] pinMeta_reg;
  logic [4:0] pinSync_reg;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pinMeta_reg <= 5'h1f;
      pinSync_reg <= 5'h1f;
    end
    else
    begin
      pinMeta_reg <= {serialIn, carrier_detect_in_n, ring_in_n, set_ready_in_n, clear_send_in_n};
      pinSync_reg <= pinMeta_reg;
    end
  end

  // handshake seen by internal logic, active high
  usmc_hs_t hsPin;
  usmc_hs_t hsLoop;
  usmc_hs_t hsNow;
  assign hsPin  = '{carrierDetect: !pinSync_reg[3], ring: !pinSync_reg[2],
                    setReady: !pinSync_reg[1], clearSend: !pinSync_reg[0]};
  assign hsLoop = '{carrierDetect: modem_line_control_reg[IRQ_GATE_BIT],
                    ring:          modem_line_control_reg[USER_OUTPUT_BIT],
                    setReady:      modem_line_control_reg[TERMINAL_READY_BIT],
                    clearSend:     modem_line_control_reg[REQUEST_SEND_BIT]};
  assign hsNow  = loopback ? hsLoop : hsPin;

  // engine wiring
  logic       txBusy;
  logic       txDone;
  logic       txLine;
  logic       rxLine;
  logic       rxDone;
  logic       rxFrameErr;
  logic [7:0] rxData;
  logic       txStart;
  assign txStart = txPend_reg && !txBusy;
  assign rxLine  = loopback ? txLine : pinSync_reg[4];

  usmc_serial_engine u_engine (
    .core_clk   (core_clk),
    .rst        (rst),
    .bitTick    (bitTick),
    .fmt        ('{charLengthSel: lineFormat_reg[1:0], stopLong: lineFormat_reg[STOP_LEN_BIT]}),
    .txStart    (txStart),
    .txData     (txHold_reg),
    .txBusy     (txBusy),
    .txDone     (txDone),
    .txLine     (txLine),
    .rxLine     (rxLine),
    .rxDone     (rxDone),
    .rxFrameErr (rxFrameErr),
    .rxData     (rxData)
  );

  // bit-tick divider: one pulse every baudDiv+1 core clocks, 16 per bit
  always_ff @(posedge core_clk)
  begin
    if (rst || divCnt_reg == '0)
      divCnt_reg <= baudDiv_reg[DIV_W-1:0];
    else
      divCnt_reg <= divCnt_reg - 1'b1;
  end
  assign bitTick = !rst && divCnt_reg == '0;

  // pins are registered so they never glitch on decode changes
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      serialOut            <= 1'b1;
      terminal_ready_out_n <= 1'b1;
      request_send_out_n   <= 1'b1;
    end
    else
    begin
      serialOut            <= loopback ? 1'b1 : txLine;
      terminal_ready_out_n <= loopback ? 1'b1 : !modem_line_control_reg[TERMINAL_READY_BIT];
      request_send_out_n   <= loopback ? 1'b1 : !modem_line_control_reg[REQUEST_SEND_BIT];
    end
  end
  // user output one has no pin; it lives in the register and reaches logic only as the loopback ring input

  // APB: zero wait states
  logic apbWrite;
  logic apbRead;
  logic hitMcr;
  logic hitFmt;
  logic hitStat;
  logic hitMask;
  logic hitMsr;
  logic hitTx;
  logic hitRx;
  logic hitDiv;
  logic mapped;
  assign apbWrite = psel && penable && pwrite;
  assign apbRead  = psel && penable && !pwrite;
  assign hitMcr   = paddr == MODEM_LINE_CONTROL_OFS;
  assign hitFmt   = paddr == LINE_FORMAT_OFS;
  assign hitStat  = paddr == EVENT_STATUS_OFS;
  assign hitMask  = paddr == EVENT_MASK_OFS;
  assign hitMsr   = paddr == MODEM_STATUS_OFS;
  assign hitTx    = paddr == TX_DATA_OFS;
  assign hitRx    = paddr == RX_DATA_OFS;
  assign hitDiv   = paddr == BAUD_DIV_OFS;
  assign mapped   = hitMcr | hitFmt | hitStat | hitMask | hitMsr | hitTx | hitRx | hitDiv;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;

  always_comb
  begin
    prdata = 32'h0;
    if (hitMcr)
      prdata[7:0] = modem_line_control_reg & MODEM_CTL_WMASK;
    else if (hitFmt)
      prdata[2:0] = lineFormat_reg;
    else if (hitStat)
      prdata[EV_W-1:0] = evStatus_reg;
    else if (hitMask)
      prdata[EV_W-1:0] = evMask_reg;
    else if (hitMsr)
      prdata[4:0] = {txBusy | txPend_reg, hsNow};
    else if (hitRx)
      prdata[7:0] = rxData;
    else if (hitDiv)
      prdata[15:0] = baudDiv_reg;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      modem_line_control_reg <= MODEM_CTL_RESET;
      lineFormat_reg         <= LINE_FORMAT_RESET[2:0];
      baudDiv_reg            <= BAUD_DIV_RESET;
      evMask_reg             <= '0;
      txHold_reg             <= 8'h00;
    end
    else if (apbWrite)
    begin
      if (hitMcr)
        modem_line_control_reg <= pwdata[7:0] & MODEM_CTL_WMASK;
      if (hitFmt)
        lineFormat_reg <= pwdata[2:0];
      if (hitDiv)
        baudDiv_reg <= pwdata[15:0];
      if (hitMask)
        evMask_reg <= pwdata[EV_W-1:0];
      if (hitTx && !txPend_reg)
        txHold_reg <= pwdata[7:0];
    end
  end

  // one pending byte; a write while pending is dropped, except in the txStart cycle, where it makes the held byte go out again
  always_ff @(posedge core_clk)
  begin
    if (rst)
      txPend_reg <= 1'b0;
    else if (apbWrite && hitTx)
      txPend_reg <= 1'b1;
    else if (txStart)
      txPend_reg <= 1'b0;
  end

  // events: sticky, cleared by status read, new event wins
  usmc_hs_t        hsPrev_reg;
  logic [EV_W-1:0] evSet;
  assign evSet = {hsNow != hsPrev_reg, rxDone && rxFrameErr, rxDone, txDone};
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      hsPrev_reg   <= '0;
      evStatus_reg <= '0;
    end
    else
    begin
      hsPrev_reg   <= hsNow;
      evStatus_reg <= evSet | ((apbRead && hitStat) ? '0 : evStatus_reg);
    end
  end

  // level interrupt, driven only while the gate bit is set
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      irqOut   <= 1'b0;
      irqOutEn <= 1'b0;
    end
    else
    begin
      irqOut   <= |(evStatus_reg & evMask_reg);
      irqOutEn <= modem_line_control_reg[IRQ_GATE_BIT];
    end
  end
endmodule // usmc_uart_modem

// >>> usmc_pkg.sv
// package: register map, field positions and carrier types of the serial modem-control block
package usmc_pkg;
  // register indices; one aligned 32-bit word each, byte address is four times the index
  localparam int         MODEM_LINE_CONTROL_IDX = 4;
  localparam int         LINE_FORMAT_IDX        = 3;
  localparam logic [7:0] MODEM_LINE_CONTROL_OFS = 8'h10;
  localparam logic [7:0] LINE_FORMAT_OFS        = 8'h0c;
  localparam logic [7:0] EVENT_STATUS_OFS       = 8'h14;
  localparam logic [7:0] EVENT_MASK_OFS         = 8'h18;
  localparam logic [7:0] MODEM_STATUS_OFS       = 8'h1c;
  localparam logic [7:0] TX_DATA_OFS            = 8'h00;
  localparam logic [7:0] RX_DATA_OFS            = 8'h20;
  localparam logic [7:0] BAUD_DIV_OFS           = 8'h24;

  localparam int TERMINAL_READY_BIT = 0;
  localparam int REQUEST_SEND_BIT   = 1;
  localparam int USER_OUTPUT_BIT    = 2;
  localparam int IRQ_GATE_BIT       = 3;
  localparam int LOOPBACK_BIT       = 4;
  localparam int STOP_LEN_BIT       = 2;

  localparam logic [7:0]  MODEM_CTL_RESET   = 8'h00;
  localparam logic [7:0]  MODEM_CTL_WMASK   = 8'h1f;
  localparam logic [7:0]  LINE_FORMAT_RESET = 8'h03;
  localparam logic [15:0] BAUD_DIV_RESET    = 16'h0010;

  // event bits: tx done, rx done, rx framing error, handshake change
  localparam int EV_TX_DONE = 0;
  localparam int EV_RX_DONE = 1;
  localparam int EV_FRAME   = 2;
  localparam int EV_MODEM   = 3;
  localparam int EV_W       = 4;

  typedef struct packed {
    logic carrierDetect;
    logic ring;
    logic setReady;
    logic clearSend;
  } usmc_hs_t;

  typedef struct packed {
    logic [1:0] charLengthSel;
    logic       stopLong;
  } usmc_fmt_t;
endpackage

// >>> usmc_serial_engine.sv
// file: bit-serial transmitter and receiver, one character at a time
`timescale 1ns/1ps
module usmc_serial_engine
  import usmc_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          bitTick,
  input  wire usmc_pkg::usmc_fmt_t fmt,
  input  wire logic          txStart,
  input  wire logic [7:0]    txData,
  output logic               txBusy,
  output logic               txDone,
  output logic               txLine,
  input  wire logic          rxLine,
  output logic               rxDone,
  output logic               rxFrameErr,
  output logic [7:0]         rxData
);
  // ticks are oversampled 16x; one bit lasts 16 ticks
  logic [3:0] dataBits;
  assign dataBits = 4'd5 + {2'b00, fmt.charLengthSel};

  // stop length in half bits: 2, or 3 for 5-bit chars, or 4 otherwise
  logic [2:0] stopHalves;
  assign stopHalves = !fmt.stopLong ? 3'd2 : (fmt.charLengthSel == 2'b00 ? 3'd3 : 3'd4);

  logic [8:0] txSh_reg;
  logic [3:0] txCnt_reg;
  logic [3:0] txTick_reg;
  logic [2:0] txHalf_reg;
  logic       txStop_reg;
  // stop bits are driven as mark directly; short characters leave data bits in the shifter
  assign txLine = (txBusy && !txStop_reg) ? txSh_reg[0] : 1'b1;
  always_ff @(posedge core_clk)
  begin
    txDone <= 1'b0;
    if (rst)
    begin
      txBusy <= 1'b0;
      txSh_reg <= 9'h1ff;
      txCnt_reg <= 4'h0;
      txTick_reg <= 4'h0;
      txHalf_reg <= 3'h0;
      txStop_reg <= 1'b0;
    end
    else if (!txBusy)
    begin
      if (txStart)
      begin
        txBusy <= 1'b1;
        txSh_reg <= {txData, 1'b0};
        txCnt_reg <= dataBits + 4'd1;
        txTick_reg <= 4'h0;
        txStop_reg <= 1'b0;
      end
    end
    else if (bitTick)
    begin
      txTick_reg <= txTick_reg + 4'd1;
      if (txStop_reg)
      begin
        if (txTick_reg[2:0] == 3'h7)
        begin
          txHalf_reg <= txHalf_reg + 3'd1;
          if (txHalf_reg + 3'd1 == stopHalves)
          begin
            txBusy <= 1'b0;
            txDone <= 1'b1;
          end
        end
      end
      else if (txTick_reg == 4'hf)
      begin
        txSh_reg <= {1'b1, txSh_reg[8:1]};
        txCnt_reg <= txCnt_reg - 4'd1;
        if (txCnt_reg == 4'd1)
        begin
          txStop_reg <= 1'b1;
          txHalf_reg <= 3'h0;
        end
      end
    end
  end

  logic       rxBusy_reg;
  logic [3:0] rxTick_reg;
  logic [3:0] rxCnt_reg;
  logic [7:0] rxSh_reg;
  always_ff @(posedge core_clk)
  begin
    rxDone <= 1'b0;
    if (rst)
    begin
      rxBusy_reg <= 1'b0;
      rxTick_reg <= 4'h0;
      rxCnt_reg <= 4'h0;
      rxSh_reg <= 8'h00;
      rxData <= 8'h00;
      rxFrameErr <= 1'b0;
    end
    else if (!rxBusy_reg)
    begin
      if (bitTick && !rxLine)
      begin
        rxBusy_reg <= 1'b1;
        rxTick_reg <= 4'h0;
        rxCnt_reg <= 4'h0;
      end
    end
    else if (bitTick)
    begin
      rxTick_reg <= rxTick_reg + 4'd1;
      if (rxTick_reg == 4'h7)
      begin
        rxCnt_reg <= rxCnt_reg + 4'd1;
        if (rxCnt_reg == 4'd0 && rxLine)
          rxBusy_reg <= 1'b0;
        else if (rxCnt_reg != 4'd0 && rxCnt_reg <= dataBits)
          rxSh_reg <= {rxLine, rxSh_reg[7:1]};
        else if (rxCnt_reg > dataBits)
        begin
          // only the first stop bit is sampled; hunt for next start at once
          rxBusy_reg <= 1'b0;
          rxDone <= 1'b1;
          rxFrameErr <= !rxLine;
          rxData <= rxSh_reg >> (4'd8 - dataBits);
        end
      end
    end
  end
endmodule // usmc_serial_engine

// >>> usmc_uart_modem_sva.sv
// checker: modem control pins, interrupt gate and register readback
`timescale 1ns/1ps
module usmc_uart_modem_sva
  import usmc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        serialOut,
  input wire logic        terminal_ready_out_n,
  input wire logic        request_send_out_n,
  input wire logic        irqOutEn
);
  logic [4:0] ctlSeen;
  logic [2:0] ctlAge;
  wire        ctlWr   = psel && penable && pwrite && paddr == MODEM_LINE_CONTROL_OFS;
  wire        ctlRd   = psel && penable && !pwrite && paddr == MODEM_LINE_CONTROL_OFS;
  wire        stRd    = psel && penable && !pwrite && paddr == MODEM_STATUS_OFS;
  wire        settled = ctlAge > 3'd3;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctlSeen <= 5'h00;
      ctlAge  <= 3'd0;
    end
    else
    begin
      ctlSeen <= ctlWr ? pwdata[4:0] : ctlSeen;
      ctlAge  <= ctlWr ? 3'd0 : ctlAge + {2'd0, ctlAge != 3'd7};
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  dtr_pin_a: assert property (settled && !ctlSeen[4] |-> terminal_ready_out_n == !ctlSeen[0])
    else $error("terminal ready pin disagrees with control bit");
  rts_pin_a: assert property (settled && !ctlSeen[4] |-> request_send_out_n == !ctlSeen[1])
    else $error("request send pin disagrees with control bit");
  loop_mark_a: assert property (settled && ctlSeen[4] |-> serialOut)
    else $error("serial output not marking in loopback");
  loop_pins_a: assert property (ctlWr && pwdata[4] |-> ##[1:3] (terminal_ready_out_n && request_send_out_n) [*4])
    else $error("handshake pins not forced high in loopback");
  irq_gate_a: assert property (settled |-> irqOutEn == ctlSeen[3])
    else $error("interrupt enable disagrees with gate bit");
  resv_zero_a: assert property (ctlRd |-> prdata[31:5] == 27'h0)
    else $error("reserved control bits not zero");
  ctl_back_a: assert property (ctlRd |-> prdata[4:0] == ctlSeen)
    else $error("control readback wrong");
  // loopback status comes straight from the control register, yet only a long-settled control value is judged
  loop_status_a: assert property (ctlAge == 3'd7 && ctlSeen[4] && stRd |->
    prdata[3:0] == {ctlSeen[3], ctlSeen[2], ctlSeen[0], ctlSeen[1]})
    else $error("loopback handshake status wrong");
endmodule // usmc_uart_modem_sva

bind usmc_uart_modem usmc_uart_modem_sva usmc_uart_modem_sva_inst (.core_clk(core_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .serialOut(serialOut),
  .terminal_ready_out_n(terminal_ready_out_n), .request_send_out_n(request_send_out_n), .irqOutEn(irqOutEn));

// >>> usmc_modem_partner.sv
// partner: modem that answers the handshake and echoes or jams the line
`timescale 1ns/1ps
module usmc_modem_partner
(
  input  wire logic       core_clk,
  input  wire logic       echoOn,
  input  wire logic [1:0] lineSense,
  input  wire logic       serialOut,
  input  wire logic       terminal_ready_out_n,
  input  wire logic       request_send_out_n,
  output logic            serialIn = 1'b1,
  output logic            clear_send_in_n = 1'b1,
  output logic            set_ready_in_n = 1'b1,
  output logic            ring_in_n = 1'b1,
  output logic            carrier_detect_in_n = 1'b1
);
  // an unechoed line toggles every cycle so a stale level cannot pass for data
  logic noise = 1'b0;
  always @(posedge core_clk)
  begin
    noise               <= !noise;
    serialIn            <= echoOn ? serialOut : noise;
    clear_send_in_n     <= request_send_out_n;
    set_ready_in_n      <= terminal_ready_out_n;
    ring_in_n           <= !lineSense[0];
    carrier_detect_in_n <= !lineSense[1];
  end
endmodule // usmc_modem_partner

// >>> usmc_uart_modem_test.sv
// testbench: register, pin, loopback, interrupt and frame timing tests
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module usmc_uart_modem_test;
  import usmc_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic        echoOn   = 1'b1;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, serialOut, serialIn, irqOut, irqOutEn, er;
  logic        tRdyN, reqN, clrN, setN, ringN, carN;
  logic [3:0]  ev;
  int          fail_count = 0;
  int          checked    = 0;
  int          cycles     = 0;
  int          lowCnt     = 0;
  int          hiCnt      = 0;
  int          base, exp, n;

  usmc_uart_modem usmc_uart_modem_inst (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serialOut(serialOut), .serialIn(serialIn), .terminal_ready_out_n(tRdyN), .request_send_out_n(reqN),
    .clear_send_in_n(clrN), .set_ready_in_n(setN), .ring_in_n(ringN), .carrier_detect_in_n(carN),
    .irqOut(irqOut), .irqOutEn(irqOutEn));
  usmc_modem_partner usmc_modem_partner_inst (.core_clk(core_clk), .echoOn(echoOn), .lineSense(2'b10),
    .serialOut(serialOut), .terminal_ready_out_n(tRdyN), .request_send_out_n(reqN), .serialIn(serialIn),
    .clear_send_in_n(clrN), .set_ready_in_n(setN), .ring_in_n(ringN), .carrier_detect_in_n(carN));

  initial
  begin
    forever #2 core_clk = ~core_clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // run lengths of the serial output give bit-exact frame timing
  always @(posedge core_clk)
  begin
    cycles++;
    lowCnt <= serialOut ? lowCnt : lowCnt + 1;
    hiCnt  <= serialOut ? hiCnt + 1 : 0;
    if (cycles == 20000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int w;
    w = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && w < 20)
    begin
      w++;
      @(posedge core_clk);
    end
    if (w == 20)
      fail_count++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    xfer(0, MODEM_LINE_CONTROL_OFS, 0);
    `CHK("ctl reset", 32'h0, rd)
    `CHK("pins reset", 2'b11, {tRdyN, reqN})
    xfer(1, MODEM_LINE_CONTROL_OFS, 32'he0);
    xfer(0, MODEM_LINE_CONTROL_OFS, 0);
    `CHK("reserved bits", 32'h0, rd)
    xfer(0, 8'h40, 0);
    `CHK("unmapped", 33'h100000000, {er, rd})
    xfer(1, BAUD_DIV_OFS, 32'h1);
    $display("test reset done");
    for (int v = 0; v < 32; v++)
    begin
      xfer(1, MODEM_LINE_CONTROL_OFS, v);
      echoOn <= !v[4];
      repeat (8) @(posedge core_clk);
      `CHK("term pin", v[4] | !v[0], tRdyN)
      `CHK("req pin", v[4] | !v[1], reqN)
      `CHK("irq gate", v[3], irqOutEn)
      `CHK("mark", 1'b1, serialOut)
      xfer(0, MODEM_LINE_CONTROL_OFS, 0);
      `CHK("ctl back", {27'h0, v[4:0]}, rd)
      xfer(0, MODEM_STATUS_OFS, 0);
      exp = v[4] ? {v[3], v[2], v[0], v[1]} : {2'b10, v[0], v[1]};
      `CHK("modem status", exp[3:0], rd[3:0])
    end
    $display("test control done");
    xfer(0, EVENT_STATUS_OFS, 0);
    xfer(1, EVENT_MASK_OFS, 32'h8);
    xfer(1, MODEM_LINE_CONTROL_OFS, 32'h1e);
    repeat (8) @(posedge core_clk);
    `CHK("irq raised", 1'b1, irqOut)
    xfer(0, EVENT_STATUS_OFS, 0);
    `CHK("modem event", 4'h8, rd[3:0])
    repeat (2) @(posedge core_clk);
    `CHK("irq cleared", 1'b0, irqOut)
    xfer(1, EVENT_MASK_OFS, 32'h0);
    xfer(1, MODEM_LINE_CONTROL_OFS, 32'h1f);
    repeat (8) @(posedge core_clk);
    `CHK("irq masked", 1'b0, irqOut)
    xfer(0, EVENT_STATUS_OFS, 0);
    `CHK("sticky event", 4'h8, rd[3:0])
    $display("test interrupt done");
    xfer(1, LINE_FORMAT_OFS, 32'h3);
    xfer(1, TX_DATA_OFS, 32'ha5);
    ev = 4'h0;
    n = 0;
    while (ev[1:0] != 2'b11 && n < 300)
    begin
      xfer(0, EVENT_STATUS_OFS, 0);
      ev = ev | rd[3:0];
      n++;
    end
    `CHK("loop events", 4'h3, ev)
    xfer(0, RX_DATA_OFS, 0);
    `CHK("loop data", 8'ha5, rd[7:0])
    $display("test loopback done");
    echoOn <= 1'b1;
    xfer(1, MODEM_LINE_CONTROL_OFS, 32'h0);
    for (int f = 0; f < 8; f++)
    begin
      xfer(1, LINE_FORMAT_OFS, f);
      xfer(0, EVENT_STATUS_OFS, 0);
      base = lowCnt;
      xfer(1, TX_DATA_OFS, 32'h0);
      rd = 32'h10;
      n = 0;
      while (rd[4] !== 1'b0 && n < 300)
      begin
        xfer(0, MODEM_STATUS_OFS, 0);
        n++;
      end
      exp = f[2] ? ((f[1:0] == 2'b00) ? 48 : 64) : 32;
      `CHK("stop length", 1'b1, hiCnt >= exp - 2 && hiCnt <= exp + 8)
      n = (6 + f[1:0]) * 32;
      `CHK("data length", 1'b1, (lowCnt - base) >= n - 1 && (lowCnt - base) <= n)
      repeat (40) @(posedge core_clk);
      xfer(0, EVENT_STATUS_OFS, 0);
      `CHK("echo events", 3'b011, rd[2:0])
    end
    $display("test frames done");
    tally_and_finish();
  end
endmodule // usmc_uart_modem_test
